//--- hdl/sdc_channel_regs.sv
// Top: one converter channel's register set on an Avalon-MM slave
//
// Overview of operation
// - Read-only 16-bit result word, reset zero, shows upper or lower filter half.
// - Input control bit 7 and channel control bits 15-11 read zero.
// - Delay bit picks fourth sample (0) or first sample (1) for first interrupt.
// - Gain codes 0-4 give x1 to x16; codes 5-7 reserved.
// - Pair codes 0-5 pick own input pair, 6 temperature sensor, 7 reserved.
// - 8-bit preload register, reset zero, is the filter start value.
// - Control bit 10: zero continuous conversion, one single conversion.
// - Oversampling codes 00,01,10,11 give 256,128,64,32.
// - With auto-toggle set each result read inverts half select.
// - Half select zero shows upper 16 bits, one shows lower 16 bits.
// - Overflow flag at bit 5, software writable, shows pending overflow.
// - Format bit: zero offset binary, one two's complement.
// - Bit 3 enables the channel conversion interrupt.
// - Done flag at bit 2 sets when a new result is available.
// - Done flag clears on result read or software write.
// - Writing one to start bit 1 starts a conversion.
// - Group bit 0 ties channel to next higher channel; ignored on last.
`timescale 1ns/1ps
module sdc_channel_regs
   import sdc_pkg::*;
#(
   parameter bit LAST_CHANNEL = 1'b0
)
(
   // Clock, reset, enable
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   input  wire logic        CE,
   // Avalon-MM slave
   input  wire logic [11:0] AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // Filter side
   input  wire sdc_sample_t FILTER_SAMPLE,
   output sdc_cfg_t         CFG,
   output logic             CONV_RUNNING,
   output logic             FILTER_PRELOAD_LOAD,
   // Interrupt requests to shared logic
   output logic             CONV_IRQ,
   output logic             OVERFLOW_IRQ
);

   logic [9:0]  reg_index;
   logic        rd_stb;
   logic        wr_stb;
   logic [6:0]  input_control_q;
   logic [7:0]  filter_preload_q;
   logic [10:0] channel_control_q;
   logic [31:0] conv_result;
   logic        result_new;
   logic        running;
   logic        start_req;
   logic        wr_inctl;
   logic        wr_pre;
   logic        wr_cctl;
   logic        rd_result;
   logic [15:0] wdata16;
   logic [15:0] cctl_d;
   logic [15:0] result_half_word;
   logic [31:0] rdata_d;
   logic        conv_done_flag;
   logic        overflow_flag;
   logic        half_select;
   logic        single_end;

   sdc_avmm_slave u_slave (
      .clk         (CLK_SYS),
      .rst_n       (RST_N),
      .ce          (CE),
      .address     (AVS_ADDRESS),
      .read        (AVS_READ),
      .write       (AVS_WRITE),
      .waitrequest (AVS_WAITREQUEST),
      .reg_index   (reg_index),
      .rd_stb      (rd_stb),
      .wr_stb      (wr_stb)
   );

   sdc_conv_seq u_seq (
      .clk           (CLK_SYS),
      .rst_n         (RST_N),
      .ce            (CE),
      .start         (start_req),
      .stop          (wr_cctl && !cctl_d[CCTL_SC_BIT]),
      .single_shot   (channel_control_q[CCTL_SNGL_BIT]),
      .first_irq_now (input_control_q[INCTL_DLY_BIT]),
      .sample        (FILTER_SAMPLE),
      .running       (running),
      .result_new    (result_new),
      .result        (conv_result)
   );

   // Byte-lane merge for the 16-bit channel control register
   assign wdata16 = {AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : {5'h00, channel_control_q[10:8]},
                     AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : channel_control_q[7:0]};

   assign wr_inctl  = wr_stb && reg_index == OFS_INPUT_CONTROL  && AVS_BYTEENABLE[0];
   assign wr_pre    = wr_stb && reg_index == OFS_FILTER_PRELOAD && AVS_BYTEENABLE[0];
   assign wr_cctl   = wr_stb && reg_index == OFS_CHANNEL_CONTROL;
   assign rd_result = rd_stb && reg_index == OFS_RESULT_WORD;
   assign cctl_d    = wdata16 & CCTL_WR_MASK;
   assign start_req = wr_cctl && cctl_d[CCTL_SC_BIT] && !running;

   assign conv_done_flag = channel_control_q[CCTL_IFG_BIT];
   assign overflow_flag  = channel_control_q[CCTL_OVF_BIT];
   assign half_select    = channel_control_q[CCTL_LSB_BIT];
   assign single_end     = running && result_new && channel_control_q[CCTL_SNGL_BIT];

   // Input control register
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         input_control_q <= RST_INPUT_CONTROL[6:0];
      end else if (CE && wr_inctl) begin
         input_control_q <= AVS_WRITEDATA[6:0] & INCTL_WR_MASK[6:0];
      end
   end

   // Filter preload register
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         filter_preload_q <= RST_FILTER_PRELOAD;
      end else if (CE && wr_pre) begin
         filter_preload_q <= AVS_WRITEDATA[7:0];
      end
   end

   // Channel control register: software bits, then hardware set and clear
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         channel_control_q <= RST_CHANNEL_CONTROL[10:0];
      end else if (CE) begin
         if (wr_cctl) begin
            channel_control_q <= cctl_d[10:0];
         end
         if (rd_result && channel_control_q[CCTL_TOG_BIT]) begin
            channel_control_q[CCTL_LSB_BIT] <= !half_select;
         end
         if (rd_result && !wr_cctl) begin
            channel_control_q[CCTL_IFG_BIT] <= 1'b0;
         end
         if (result_new) begin
            channel_control_q[CCTL_IFG_BIT] <= 1'b1;
         end
         if (FILTER_SAMPLE.valid && FILTER_SAMPLE.overflow && running) begin
            channel_control_q[CCTL_OVF_BIT] <= 1'b1;
         end
         if (start_req) begin
            channel_control_q[CCTL_SC_BIT] <= 1'b1;
         end else if (single_end) begin
            channel_control_q[CCTL_SC_BIT] <= 1'b0;
         end
         if (LAST_CHANNEL) begin
            channel_control_q[CCTL_GRP_BIT] <= 1'b0;
         end
      end
   end

   // Result half selection
   assign result_half_word = half_select ? conv_result[15:0] : conv_result[31:16];

   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (reg_index)
         OFS_INPUT_CONTROL:   rdata_d = {25'h0, input_control_q};
         OFS_FILTER_PRELOAD:  rdata_d = {24'h0, filter_preload_q};
         OFS_CHANNEL_CONTROL: rdata_d = {21'h0, channel_control_q};
         OFS_RESULT_WORD:     rdata_d = {16'h0, result_half_word};
         OFS_FILTER_STATUS:   rdata_d = {31'h0, running};
         default:             rdata_d = 32'h0000_0000;
      endcase
   end

   // Read data loaded in the wait cycle, stands when waitrequest drops
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (CE && AVS_READ && AVS_WAITREQUEST) begin
         AVS_READDATA <= rdata_d;
      end
   end

   // Settings toward modulator and filter
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         CFG                 <= '0;
         CONV_RUNNING        <= 1'b0;
         FILTER_PRELOAD_LOAD <= 1'b0;
      end else if (CE) begin
         CFG.single_shot_sel    <= channel_control_q[CCTL_SNGL_BIT];
         CFG.oversample_ratio   <= sdc_osr(channel_control_q[9:8]);
         CFG.result_format_sel  <= channel_control_q[CCTL_DF_BIT];
         CFG.preamp_gain        <= sdc_gain(input_control_q[5:3]);
         CFG.input_pair_sel     <= input_control_q[2:0];
         CFG.temp_sensor_sel    <= input_control_q[2:0] == PAIR_TEMP_CODE;
         CFG.group_with_next    <= channel_control_q[CCTL_GRP_BIT] && !LAST_CHANNEL;
         CFG.filter_start_value <= filter_preload_q;
         CONV_RUNNING           <= running;
         FILTER_PRELOAD_LOAD    <= start_req;
      end
   end

   // Interrupt requests
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         CONV_IRQ     <= 1'b0;
         OVERFLOW_IRQ <= 1'b0;
      end else if (CE) begin
         CONV_IRQ     <= conv_done_flag && channel_control_q[CCTL_IE_BIT];
         OVERFLOW_IRQ <= overflow_flag;
      end
   end

endmodule : sdc_channel_regs

//--- hdl/sdc_pkg.sv
// Package with register map, field layout and types of the converter channel registers
package sdc_pkg;

   // Register offsets (printed offsets; some odd, so these are indices, byte addr = 4*index)
   localparam logic [9:0] OFS_INPUT_CONTROL   = 10'h0b5;
   localparam logic [9:0] OFS_FILTER_PRELOAD  = 10'h0bd;
   localparam logic [9:0] OFS_CHANNEL_CONTROL = 10'h10e;
   localparam logic [9:0] OFS_RESULT_WORD     = 10'h11a;
   localparam logic [9:0] OFS_FILTER_STATUS   = 10'h120;

   // Input control fields
   localparam int         INCTL_DLY_BIT   = 6;
   localparam int         INCTL_GAIN_LSB  = 3;
   localparam int         INCTL_PAIR_LSB  = 0;
   localparam logic [7:0] INCTL_WR_MASK   = 8'h7f;

   // Channel control fields
   localparam int          CCTL_SNGL_BIT  = 10;
   localparam int          CCTL_OSR_LSB   = 8;
   localparam int          CCTL_TOG_BIT   = 7;
   localparam int          CCTL_LSB_BIT   = 6;
   localparam int          CCTL_OVF_BIT   = 5;
   localparam int          CCTL_DF_BIT    = 4;
   localparam int          CCTL_IE_BIT    = 3;
   localparam int          CCTL_IFG_BIT   = 2;
   localparam int          CCTL_SC_BIT    = 1;
   localparam int          CCTL_GRP_BIT   = 0;
   localparam logic [15:0] CCTL_WR_MASK   = 16'h07ff;

   // Reset values
   localparam logic [7:0]  RST_INPUT_CONTROL   = 8'h00;
   localparam logic [7:0]  RST_FILTER_PRELOAD  = 8'h00;
   localparam logic [15:0] RST_CHANNEL_CONTROL = 16'h0000;
   localparam logic [15:0] RST_RESULT_WORD     = 16'h0000;

   // Field codes
   localparam logic [2:0] GAIN_MAX_CODE   = 3'h4;
   localparam logic [2:0] PAIR_TEMP_CODE  = 3'h6;
   localparam logic [2:0] PAIR_RSVD_CODE  = 3'h7;
   localparam logic [1:0] FIRST_IRQ_LATE  = 2'h3;

   // Read answer latency in cycles
   localparam int READ_WAIT_CYCLES = 1;

   typedef enum logic [1:0] {
      SDC_IDLE,
      SDC_RUN,
      SDC_STOP
   } sdc_conv_state_t;

   // Settings handed to the modulator and filter
   typedef struct packed {
      logic        single_shot_sel;
      logic [8:0]  oversample_ratio;
      logic        result_format_sel;
      logic [4:0]  preamp_gain;
      logic [2:0]  input_pair_sel;
      logic        temp_sensor_sel;
      logic        group_with_next;
      logic [7:0]  filter_start_value;
   } sdc_cfg_t;

   // Filter sample from the arithmetic
   typedef struct packed {
      logic        valid;
      logic        overflow;
      logic [31:0] data;
   } sdc_sample_t;

   // Gain code to gain factor, zero for reserved codes
   function automatic logic [4:0] sdc_gain(input logic [2:0] code);
      sdc_gain = (code > GAIN_MAX_CODE) ? 5'h00 : 5'(5'h01 << code);
   endfunction : sdc_gain

   // Oversampling code to ratio
   function automatic logic [8:0] sdc_osr(input logic [1:0] code);
      sdc_osr = 9'(9'h100 >> code);
   endfunction : sdc_osr

endpackage : sdc_pkg

//--- hdl/sdc_avmm_slave.sv
// Avalon-MM slave front end: decodes word index, one wait state on every access
`timescale 1ns/1ps
module sdc_avmm_slave
   import sdc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // Bus side
   input  wire logic [11:0] address,
   input  wire logic        read,
   input  wire logic        write,
   output logic             waitrequest,
   // Register side
   output logic [9:0]       reg_index,
   output logic             rd_stb,
   output logic             wr_stb
);

   logic wait_q;

   // Registered waitrequest: drops for the second cycle of each access
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wait_q <= 1'b1;
      end else if (ce) begin
         wait_q <= !((read || write) && wait_q);
      end
   end

   assign reg_index   = address[11:2];
   assign waitrequest = wait_q;
   assign rd_stb      = read && !wait_q && ce;
   assign wr_stb      = write && !wait_q && ce;

endmodule : sdc_avmm_slave

//--- hdl/sdc_conv_seq.sv
// Conversion sequencer: run state, first interrupt delay and result capture
`timescale 1ns/1ps
module sdc_conv_seq
   import sdc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // Control
   input  wire logic        start,
   input  wire logic        stop,
   input  wire logic        single_shot,
   input  wire logic        first_irq_now,
   input  wire sdc_sample_t sample,
   // Status
   output logic             running,
   output logic             result_new,
   output logic [31:0]      result
);

   sdc_conv_state_t state_q;
   logic [1:0]      skip_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= SDC_IDLE;
         skip_q  <= 2'h0;
      end else if (ce) begin
         unique case (state_q)
            SDC_IDLE: begin
               if (start) begin
                  state_q <= SDC_RUN;
                  skip_q  <= first_irq_now ? 2'h0 : FIRST_IRQ_LATE;
               end
            end
            SDC_RUN: begin
               if (stop) begin
                  state_q <= SDC_IDLE;
               end else if (sample.valid) begin
                  if (skip_q != 2'h0) begin
                     skip_q <= skip_q - 2'h1;
                  end else if (single_shot) begin
                     state_q <= SDC_STOP;
                  end
               end
            end
            SDC_STOP: state_q <= SDC_IDLE;
            default:  state_q <= SDC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result <= 32'h0000_0000;
      end else if (ce && result_new) begin
         result <= sample.data;
      end
   end

   assign running    = state_q == SDC_RUN;
   assign result_new = running && sample.valid && skip_q == 2'h0 && !stop;

endmodule : sdc_conv_seq

//--- testbench/sdc_channel_regs_assertions.sv
// Assertion checker for the channel register block
`timescale 1ns/1ps
module sdc_channel_regs_chk
   import sdc_pkg::*;
(
   // Clock and reset
   input wire logic        CLK_SYS,
   input wire logic        RST_N,
   // Bus
   input wire logic [11:0] AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   // Filter side
   input wire sdc_sample_t FILTER_SAMPLE,
   input wire sdc_cfg_t    CFG,
   input wire logic        CONV_RUNNING,
   input wire logic        CONV_IRQ
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   wire logic [9:0] idx    = AVS_ADDRESS[11:2];
   wire logic       rd_ok  = AVS_READ && !AVS_WAITREQUEST;
   wire logic       wr_ok  = AVS_WRITE && !AVS_WAITREQUEST;
   wire logic       ctl_wr = wr_ok && idx == OFS_CHANNEL_CONTROL;
   wire logic       in_wr  = wr_ok && idx == OFS_INPUT_CONTROL;
   wire logic       res_rd = rd_ok && idx == OFS_RESULT_WORD;

   chk_ctl_rsvd_zero: assert property (
      rd_ok && idx == OFS_CHANNEL_CONTROL |-> AVS_READDATA[15:11] == 5'h00)
      else $error("control reserved bits not zero");
   chk_inctl_rsvd_zero: assert property (
      rd_ok && idx == OFS_INPUT_CONTROL |-> !AVS_READDATA[7])
      else $error("input control bit 7 not zero");
   chk_pair_update: assert property (
      in_wr |-> ##2 CFG.input_pair_sel == $past(AVS_WRITEDATA[2:0], 2))
      else $error("input pair not taken from write");
   chk_temp_decode: assert property (
      CFG.temp_sensor_sel == (CFG.input_pair_sel == PAIR_TEMP_CODE))
      else $error("temperature sensor select wrong");
   chk_preload_update: assert property (
      wr_ok && idx == OFS_FILTER_PRELOAD |-> ##2
         CFG.filter_start_value == $past(AVS_WRITEDATA[7:0], 2))
      else $error("preload not taken from write");
   chk_mode_fmt: assert property (
      ctl_wr |-> ##2 CFG.single_shot_sel == $past(AVS_WRITEDATA[10], 2)
         && CFG.result_format_sel == $past(AVS_WRITEDATA[4], 2))
      else $error("mode or format not taken from write");
   chk_osr_ratio: assert property (
      ctl_wr |-> ##2 CFG.oversample_ratio == (9'h100 >> $past(AVS_WRITEDATA[9:8], 2)))
      else $error("oversampling ratio wrong");
   chk_ie_off_irq: assert property (
      ctl_wr && !AVS_WRITEDATA[3] |-> ##2 !CONV_IRQ)
      else $error("interrupt with enable cleared");
   chk_read_clear: assert property (
      res_rd && !FILTER_SAMPLE.valid && !$past(FILTER_SAMPLE.valid) |-> ##2 !CONV_IRQ)
      else $error("done flag not cleared by result read");
   chk_start_runs: assert property (
      ctl_wr && AVS_WRITEDATA[CCTL_SC_BIT] |-> ##[1:3] CONV_RUNNING)
      else $error("start did not run conversion");
   chk_irq_cause: assert property (
      $rose(CONV_IRQ) |-> $past(FILTER_SAMPLE.valid) || $past(FILTER_SAMPLE.valid, 2)
         || $past(FILTER_SAMPLE.valid, 3) || $past(wr_ok, 2))
      else $error("interrupt without cause");

   cov_res_read: cover property (res_rd);
   cov_irq_rise: cover property ($rose(CONV_IRQ));
   cov_run_rise: cover property ($rose(CONV_RUNNING));
endmodule : sdc_channel_regs_chk

bind sdc_channel_regs sdc_channel_regs_chk chk_u (
   .CLK_SYS(CLK_SYS), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .FILTER_SAMPLE(FILTER_SAMPLE), .CFG(CFG),
   .CONV_RUNNING(CONV_RUNNING), .CONV_IRQ(CONV_IRQ));

//--- testbench/sdc_channel_regs_tb_top.sv
// Self-checking testbench for the channel register block
`timescale 1ns/1ps
module sdc_channel_regs_tb_top
   import sdc_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] addr = 12'h000;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata;
   logic        wreq;
   sdc_sample_t smp = '0;
   sdc_cfg_t    cfg;
   logic        run;
   logic        irq;
   logic [31:0] v;
   int          mismatches = 0;
   int          compares = 0;
   logic [4:0]  gains [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
   logic [8:0]  ratios [4] = '{9'h100, 9'h080, 9'h040, 9'h020};

   always #2.5 clk = ~clk;

   sdc_channel_regs dut_u (
      .CLK_SYS(clk), .RST_N(rst_n), .CE(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wreq), .FILTER_SAMPLE(smp), .CFG(cfg), .CONV_RUNNING(run),
      .FILTER_PRELOAD_LOAD(), .CONV_IRQ(irq), .OVERFLOW_IRQ());

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up;
      $display("Mismatches %0d, compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up

   // One bus cycle, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      addr <= {i, 2'b00};
      rd <= !w;
      wr <= w;
      wd <= d;
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic wreg(input logic [9:0] i, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, i, d, q);
   endtask : wreg

   task automatic rchk(input logic [9:0] i, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] q;
      bus(1'b0, i, 32'h0, q);
      check(q & m, e);
   endtask : rchk

   task automatic sample(input logic [31:0] d);
      @(posedge clk);
      smp <= '{valid: 1'b1, overflow: 1'b0, data: d};
      @(posedge clk);
      smp <= '{valid: 1'b0, overflow: 1'b0, data: ~d};
      repeat (4) @(posedge clk);
   endtask : sample

   // Bounded wait on running (sel high) or interrupt, then compare
   task automatic wait_sig(input logic sel, input logic want);
      int n;
      for (n = 0; n < 20 && (sel ? run : irq) !== want; n++) @(posedge clk);
      check(sel ? run : irq, want);
   endtask : wait_sig

   task automatic t_reset;
      rchk(OFS_INPUT_CONTROL, 32'h0, 32'hff);
      rchk(OFS_FILTER_PRELOAD, 32'h0, 32'hff);
      rchk(OFS_CHANNEL_CONTROL, 32'h0, 32'hffff);
      rchk(OFS_RESULT_WORD, 32'h0, 32'hffff);
      bus(1'b0, 10'h001, 32'h0, v);
   endtask : t_reset

   task automatic t_inctl;
      for (int i = 0; i < 8; i++) begin
         wreg(OFS_INPUT_CONTROL, {24'h0, 1'b1, i[0], i[2:0], i[2:0]});
         rchk(OFS_INPUT_CONTROL, {24'h0, 1'b0, i[0], i[2:0], i[2:0]}, 32'hff);
         check(cfg.input_pair_sel, i[2:0]);
         check(cfg.temp_sensor_sel, i == 6);
         if (i < 5) check(cfg.preamp_gain, gains[i]);
      end
   endtask : t_inctl

   task automatic t_pre;
      for (int k = 0; k < 2; k++) begin
         v = k ? 32'h5a : 32'ha5;
         wreg(OFS_FILTER_PRELOAD, v);
         rchk(OFS_FILTER_PRELOAD, v, 32'hff);
         check(cfg.filter_start_value, v[7:0]);
      end
   endtask : t_pre

   task automatic t_ctl;
      for (int j = 0; j < 4; j++) begin
         v = {16'h0, 5'h1f, j[0], j[1:0], 3'h0, j[1], 3'h0, j[0]};
         wreg(OFS_CHANNEL_CONTROL, v);
         rchk(OFS_CHANNEL_CONTROL, v & 32'h07ff, 32'hffff);
         check(cfg.oversample_ratio, ratios[j]);
         check(cfg.single_shot_sel, j[0]);
         check(cfg.result_format_sel, j[1]);
         check(cfg.group_with_next, j[0]);
      end
      wreg(OFS_CHANNEL_CONTROL, 32'h0);
   endtask : t_ctl

   task automatic t_conv;
      wreg(OFS_INPUT_CONTROL, 32'h40);
      wreg(OFS_CHANNEL_CONTROL, 32'h000a);
      wait_sig(1'b1, 1'b1);
      sample(32'h12345678);
      wait_sig(1'b0, 1'b1);
      rchk(OFS_CHANNEL_CONTROL, 32'h4, 32'h4);
      rchk(OFS_RESULT_WORD, 32'h1234, 32'hffff);
      wait_sig(1'b0, 1'b0);
      wreg(OFS_CHANNEL_CONTROL, 32'h0088);
      for (int k = 0; k < 3; k++) rchk(OFS_RESULT_WORD, k[0] ? 32'h5678 : 32'h1234, 32'hffff);
      rchk(OFS_CHANNEL_CONTROL, 32'h00c8, 32'h00f8);
      wreg(OFS_CHANNEL_CONTROL, 32'h0040);
      for (int k = 0; k < 2; k++) rchk(OFS_RESULT_WORD, 32'h5678, 32'hffff);
   endtask : t_conv

   task automatic t_delay;
      wreg(OFS_INPUT_CONTROL, 32'h00);
      wreg(OFS_CHANNEL_CONTROL, 32'h000a);
      wait_sig(1'b1, 1'b1);
      for (int k = 0; k < 3; k++) sample(32'hcafe0000 + k);
      check(irq, 1'b0);
      sample(32'h89abcdef);
      wait_sig(1'b0, 1'b1);
      wreg(OFS_CHANNEL_CONTROL, 32'h0);
      wait_sig(1'b0, 1'b0);
      rchk(OFS_CHANNEL_CONTROL, 32'h0, 32'h4);
      wreg(OFS_CHANNEL_CONTROL, 32'h20);
      rchk(OFS_CHANNEL_CONTROL, 32'h20, 32'h20);
   endtask : t_delay

   task automatic t_single;
      wreg(OFS_INPUT_CONTROL, 32'h40);
      wreg(OFS_CHANNEL_CONTROL, 32'h040a);
      wait_sig(1'b1, 1'b1);
      sample(32'h0badf00d);
      wait_sig(1'b1, 1'b0);
      rchk(OFS_CHANNEL_CONTROL, 32'h0404, 32'h0406);
      rchk(OFS_RESULT_WORD, 32'h0bad, 32'hffff);
      wreg(OFS_CHANNEL_CONTROL, 32'h0002);
      wait_sig(1'b1, 1'b1);
      @(posedge clk);
      smp <= '{valid: 1'b1, overflow: 1'b1, data: 32'h0};
      @(posedge clk);
      smp <= '0;
      rchk(OFS_CHANNEL_CONTROL, 32'h20, 32'h20);
      wreg(OFS_CHANNEL_CONTROL, 32'h0);
   endtask : t_single

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_inctl;
      t_pre;
      t_ctl;
      t_conv;
      t_delay;
      t_single;
      wrap_up;
   end

   // Watchdog well beyond the expected run length
   initial begin
      #100000;
      mismatches++;
      wrap_up;
   end
endmodule : sdc_channel_regs_tb_top
